// *** hdl/auto_ack_radio_transactions.sv ***
// Auto-acknowledge and retransmit controller of a packet radio link layer
//
// Functional notes
// - Packet goes on air 130 us after activation
// - Transmitter turns to receive after sending
// - Receiver flags host, then returns acknowledge
// - Acknowledge received: flag host, pop packet
// - Data-received flag once packet fully received
// - Data-sent flag on transmitter only when acknowledge arrives
// - No acknowledge in slot: retransmit same packet
// - Address matched: stay receiving until done
// - Queued acknowledge payload rides in acknowledge
// - Payload data-sent only after next new packet
// - Duplicate identifier: discard, still acknowledge
// - Retry limit: flag, keep packet queued
`timescale 1ns/1ns
`include "link_defines.svh"

module auto_ack_radio_transactions #(
    parameter logic [`TMR_W-1:0] TURN_CYC     = `TMR_W'(`TURN_CYC),
    parameter logic [`TMR_W-1:0] ACK_WAIT_CYC = `TMR_W'(`ACK_WAIT_CYC)
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Host control
    input  wire logic              radio_enable,
    input  wire logic              primary_tx_mode,
    input  wire logic [`RTX_W-1:0] retransmit_limit,
    input  wire logic              tx_pending,
    input  wire logic [`PID_W-1:0] tx_pid,
    input  wire logic              ack_payload_ready,
    input  wire logic [`IRQ_N-1:0] irq_clear,
    // Host status
    output logic                   data_received_irq,
    output logic                   data_sent_irq,
    output logic                   retry_limit_irq,
    output logic                   tx_pop,
    output logic                   ack_payload_pop,
    output logic [`RTX_W-1:0]      retransmit_counter,
    // Air side, transmit
    output logic                   air_tx_start,
    output logic                   air_tx_is_ack,
    output logic                   air_tx_with_payload,
    output logic [`PID_W-1:0]      air_tx_pid,
    input  wire logic              air_tx_done,
    // Air side, receive
    output logic                   air_rx_enable,
    input  wire logic              air_addr_match,
    input  wire logic              air_rx_done,
    input  wire logic              air_rx_crc_ok,
    input  wire logic              air_rx_is_ack,
    input  wire logic              air_rx_has_payload,
    input  wire logic [`PID_W-1:0] air_rx_pid
);

    link_pkg::link_state_t s;
    link_pkg::link_state_t next_s;
    logic                  tmr_load;
    logic [`TMR_W-1:0]     tmr_val;
    logic                  tmr_zero;
    logic                  activated;
    logic                  ack_ok;
    logic                  data_ok;
    logic                  new_pid;
    logic                  timeout;
    logic [`IRQ_N-1:0]     flags;

    // ************************************************************
    // Decode of air events
    // ************************************************************
    assign activated = radio_enable && (s.act_cnt == `ACT_W'(`ACTIVATE_CYC));
    assign ack_ok    = air_rx_done && air_rx_crc_ok && air_rx_is_ack;
    assign data_ok   = air_rx_done && air_rx_crc_ok && !air_rx_is_ack;
    assign new_pid   = !s.pid_valid || (air_rx_pid != s.last_pid);
    // Address seen this cycle also holds off the slot expiry
    assign timeout   = tmr_zero && !s.addr_hold && !air_addr_match && !air_rx_done;

    // ************************************************************
    // Transaction sequencer
    // ************************************************************
    always_comb begin
        next_s         = s;
        next_s.tx_start = 1'b0;
        next_s.tx_pop   = 1'b0;
        next_s.pay_pop  = 1'b0;
        next_s.irq_set  = '0;
        tmr_load        = 1'b0;
        tmr_val         = TURN_CYC;
        // Enable must drop before a locked sequence may restart
        if (!radio_enable) begin
            next_s.act_cnt = '0;
            next_s.locked  = 1'b0;
        end else if (!activated) begin
            next_s.act_cnt = s.act_cnt + `ACT_W'(1);
        end
        unique case (s.phase)
            link_pkg::PH_IDLE: begin
                next_s.rx_en = 1'b0;
                if (primary_tx_mode) begin
                    if (activated && !s.locked && tx_pending) begin
                        next_s.rtx   = '0;
                        next_s.phase = link_pkg::PH_SETTLE;
                        tmr_load     = 1'b1;
                    end
                end else if (radio_enable) begin
                    next_s.rx_en = 1'b1;
                    next_s.phase = link_pkg::PH_LISTEN;
                end
            end
            link_pkg::PH_SETTLE: begin
                if (tmr_zero) begin
                    next_s.tx_start  = 1'b1;
                    next_s.tx_is_ack = 1'b0;
                    next_s.tx_pay    = 1'b0;
                    next_s.tx_pid    = tx_pid;
                    next_s.phase     = link_pkg::PH_SEND;
                end
            end
            link_pkg::PH_SEND: begin
                if (air_tx_done) begin
                    next_s.rx_en     = 1'b1;
                    next_s.addr_hold = 1'b0;
                    next_s.phase     = link_pkg::PH_WAIT_ACK;
                    tmr_load         = 1'b1;
                    tmr_val          = ACK_WAIT_CYC;
                end
            end
            link_pkg::PH_WAIT_ACK: begin
                if (air_addr_match) begin
                    next_s.addr_hold = 1'b1;
                end
                if (air_rx_done) begin
                    next_s.addr_hold = 1'b0;
                end
                if (ack_ok) begin
                    next_s.irq_set[`IRQ_TX] = 1'b1;
                    next_s.irq_set[`IRQ_RX] = air_rx_has_payload;
                    next_s.tx_pop           = 1'b1;
                    next_s.rx_en            = 1'b0;
                    next_s.phase            = link_pkg::PH_IDLE;
                end else if (timeout) begin
                    next_s.rx_en = 1'b0;
                    if (s.rtx >= retransmit_limit) begin
                        // Packet stays queued; host flushes or toggles enable
                        next_s.irq_set[`IRQ_RT] = 1'b1;
                        next_s.locked           = 1'b1;
                        next_s.phase            = link_pkg::PH_IDLE;
                    end else begin
                        next_s.rtx   = s.rtx + `RTX_W'(1);
                        next_s.phase = link_pkg::PH_SETTLE;
                        tmr_load     = 1'b1;
                    end
                end
            end
            link_pkg::PH_LISTEN: begin
                if (!radio_enable) begin
                    next_s.rx_en = 1'b0;
                    next_s.phase = link_pkg::PH_IDLE;
                end else if (data_ok) begin
                    if (new_pid) begin
                        next_s.irq_set[`IRQ_RX] = 1'b1;
                        next_s.last_pid         = air_rx_pid;
                        next_s.pid_valid        = 1'b1;
                        if (s.ack_inflight) begin
                            next_s.irq_set[`IRQ_TX] = 1'b1;
                            next_s.pay_pop          = 1'b1;
                            next_s.ack_inflight     = 1'b0;
                        end
                    end
                    // Duplicates fall through to the acknowledge unflagged
                    next_s.rx_en = 1'b0;
                    next_s.phase = link_pkg::PH_ACK_SETTLE;
                    tmr_load     = 1'b1;
                end
            end
            link_pkg::PH_ACK_SETTLE: begin
                if (tmr_zero) begin
                    next_s.tx_start  = 1'b1;
                    next_s.tx_is_ack = 1'b1;
                    next_s.tx_pay    = ack_payload_ready;
                    next_s.tx_pid    = s.last_pid;
                    next_s.phase     = link_pkg::PH_ACK_SEND;
                end
            end
            link_pkg::PH_ACK_SEND: begin
                if (air_tx_done) begin
                    next_s.ack_inflight = s.ack_inflight | s.tx_pay;
                    next_s.rx_en        = 1'b1;
                    next_s.phase        = link_pkg::PH_LISTEN;
                end
            end
            default: begin
                next_s.rx_en = 1'b0;
                next_s.phase = link_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Timer and flags
    // ************************************************************
    phase_timer u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .zero     (tmr_zero)
    );

    irq_flags u_flags (
        .core_clk (core_clk),
        .rst      (rst),
        .set      (s.irq_set),
        .clr      (irq_clear),
        .flags    (flags)
    );

    assign data_received_irq   = flags[`IRQ_RX];
    assign data_sent_irq       = flags[`IRQ_TX];
    assign retry_limit_irq     = flags[`IRQ_RT];
    assign tx_pop              = s.tx_pop;
    assign ack_payload_pop     = s.pay_pop;
    assign retransmit_counter  = s.rtx;
    assign air_tx_start        = s.tx_start;
    assign air_tx_is_ack       = s.tx_is_ack;
    assign air_tx_with_payload = s.tx_pay;
    assign air_tx_pid          = s.tx_pid;
    assign air_rx_enable       = s.rx_en;

    // ************************************************************
    // Checks
    // ************************************************************
    logic [`TMR_W-1:0] turn_cnt;

    always_ff @(posedge core_clk) begin
        if (rst || air_tx_start) begin
            turn_cnt <= '0;
        end else if (s.phase == link_pkg::PH_SETTLE) begin
            turn_cnt <= turn_cnt + `TMR_ONE;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_turn_delay: assert property (
        air_tx_start && !air_tx_is_ack |-> turn_cnt >= TURN_CYC)
        else $error("packet started before turnaround elapsed");

    a_rx_after_tx: assert property (
        s.phase == link_pkg::PH_SEND && air_tx_done |=> air_rx_enable && tmr_zero == 1'b0)
        else $error("no receive after packet sent");

    a_ack_turn: assert property (
        s.phase == link_pkg::PH_LISTEN && radio_enable && data_ok
        |=> s.phase == link_pkg::PH_ACK_SETTLE && !air_rx_enable)
        else $error("receiver did not turn to acknowledge");

    a_ack_pop: assert property (
        s.phase == link_pkg::PH_WAIT_ACK && ack_ok |=> tx_pop ##1 (data_sent_irq && !tx_pop))
        else $error("acknowledge did not pop packet");

    a_rx_flag: assert property (
        s.phase == link_pkg::PH_LISTEN && radio_enable && data_ok && new_pid |-> ##2 data_received_irq)
        else $error("data received flag missing");

    a_sent_cause: assert property (
        $rose(data_sent_irq) |-> $past(s.irq_set[`IRQ_TX]))
        else $error("data sent flag without acknowledge");

    a_retry_timeout: assert property (
        s.phase == link_pkg::PH_WAIT_ACK && !ack_ok && timeout && s.rtx < retransmit_limit
        |=> s.phase == link_pkg::PH_SETTLE && s.rtx == $past(s.rtx) + `RTX_W'(1))
        else $error("missed acknowledge not retransmitted");

    a_hold_addr: assert property (
        s.phase == link_pkg::PH_WAIT_ACK && s.addr_hold && !air_rx_done |=> s.phase == link_pkg::PH_WAIT_ACK)
        else $error("left receive during matched packet");

    a_ack_payload: assert property (
        air_tx_start && air_tx_is_ack |-> air_tx_with_payload == $past(ack_payload_ready))
        else $error("acknowledge payload not carried");

    a_pay_confirm: assert property (
        ack_payload_pop |-> !$past(air_tx_start) ##1 data_sent_irq)
        else $error("payload pop without data sent flag");

    a_dup_discard: assert property (
        s.phase == link_pkg::PH_LISTEN && radio_enable && data_ok && !new_pid
        |=> s.irq_set == '0 && s.phase == link_pkg::PH_ACK_SETTLE)
        else $error("duplicate packet flagged or not acknowledged");

    a_limit_keep: assert property (
        s.phase == link_pkg::PH_WAIT_ACK && !ack_ok && timeout && s.rtx >= retransmit_limit
        |=> !tx_pop ##1 (retry_limit_irq && s.phase == link_pkg::PH_IDLE))
        else $error("retry limit handling wrong");

endmodule // auto_ack_radio_transactions

// *** hdl/link_defines.svh ***
// Constants for the auto-acknowledge link controller
`ifndef LINK_DEFINES_SVH
`define LINK_DEFINES_SVH

`define CLK_MHZ        100
`define ACTIVATE_US    10
`define ACTIVATE_CYC   (`ACTIVATE_US * `CLK_MHZ)
`define TURN_US        130
`define TURN_CYC       (`TURN_US * `CLK_MHZ)
`define ACK_WAIT_US    250
`define ACK_WAIT_CYC   (`ACK_WAIT_US * `CLK_MHZ)
`define TMR_W          16
`define ACT_W          10
`define RTX_W          4
`define PID_W          2
`define IRQ_N          3
`define IRQ_RX         0
`define IRQ_TX         1
`define IRQ_RT         2
`define TMR_ZERO       16'h0000
`define TMR_ONE        16'h0001

`endif

// *** hdl/link_pkg.sv ***
// Types shared by the auto-acknowledge link controller
`include "link_defines.svh"

package link_pkg;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SETTLE,
        PH_SEND,
        PH_WAIT_ACK,
        PH_LISTEN,
        PH_ACK_SETTLE,
        PH_ACK_SEND
    } phase_t;

    typedef struct packed {
        phase_t              phase;
        logic [`ACT_W-1:0]   act_cnt;
        logic                locked;
        logic [`RTX_W-1:0]   rtx;
        logic                addr_hold;
        logic [`PID_W-1:0]   last_pid;
        logic                pid_valid;
        logic                ack_inflight;
        logic                tx_start;
        logic                tx_is_ack;
        logic                tx_pay;
        logic [`PID_W-1:0]   tx_pid;
        logic                rx_en;
        logic                tx_pop;
        logic                pay_pop;
        logic [`IRQ_N-1:0]   irq_set;
    } link_state_t;

    typedef struct packed {
        logic [`TMR_W-1:0] cnt;
    } tmr_state_t;

    typedef struct packed {
        logic [`IRQ_N-1:0] flag;
    } irq_state_t;

endpackage

// *** hdl/phase_timer.sv ***
// Down counter timing the radio turnaround and acknowledge wait
`timescale 1ns/1ns
`include "link_defines.svh"

module phase_timer (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Control
    input  wire logic              load,
    input  wire logic [`TMR_W-1:0] load_val,
    // Status
    output logic                   zero
);

    link_pkg::tmr_state_t s;
    link_pkg::tmr_state_t next_s;

    always_comb begin
        next_s = s;
        if (load) begin
            next_s.cnt = load_val;
        end else if (s.cnt != `TMR_ZERO) begin
            next_s.cnt = s.cnt - `TMR_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign zero = (s.cnt == `TMR_ZERO);

endmodule // phase_timer

// *** hdl/irq_flags.sv ***
// Sticky interrupt flags, set wins over clear
`timescale 1ns/1ns
`include "link_defines.svh"

module irq_flags (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Events and host clears
    input  wire logic [`IRQ_N-1:0] set,
    input  wire logic [`IRQ_N-1:0] clr,
    // Flags
    output logic [`IRQ_N-1:0]     flags
);

    link_pkg::irq_state_t s;
    link_pkg::irq_state_t next_s;
    logic [`IRQ_N-1:0]    next_bits;

    genvar i;
    generate
        for (i = 0; i < `IRQ_N; i++) begin : g_flag
            assign next_bits[i] = set[i] | (s.flag[i] & ~clr[i]);
        end
    endgenerate

    always_comb begin
        next_s      = s;
        next_s.flag = next_bits;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign flags = s.flag;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_flag_hold: assert property (
        (flags != '0) && (clr == '0) |=> ((flags & $past(flags)) == $past(flags)))
        else $error("pending flag lost without a clear");

endmodule // irq_flags

// *** sim/air_peer.sv ***
// Behavioural peer radio and local air timing for the link controller bench
`timescale 1ns/1ns
`include "link_defines.svh"

module air_peer (
    // Clock
    input  wire logic              core_clk,
    // Air side of the design
    input  wire logic              air_tx_start,
    input  wire logic              air_tx_is_ack,
    input  wire logic [`PID_W-1:0] air_tx_pid,
    output logic                   air_tx_done,
    output logic                   air_addr_match,
    output logic                   air_rx_done,
    output logic                   air_rx_crc_ok,
    output logic                   air_rx_is_ack,
    output logic                   air_rx_has_payload,
    output logic [`PID_W-1:0]      air_rx_pid,
    // Scenario control
    input  wire logic              drop_ack,
    input  wire logic              ack_pay,
    input  wire logic [7:0]        ack_delay,
    input  wire logic              inject,
    input  wire logic [`PID_W-1:0] inj_ident
);
    task automatic hop(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Once the done pulse is over, the qualifiers go to their inverse and the checksum flag drops to 0
    task automatic deliver(input logic [`PID_W-1:0] ident, input logic is_ack, input logic pay, input logic crc);
        air_addr_match <= 1'b1;
        hop(1);
        air_addr_match <= 1'b0;
        hop(19);
        air_rx_done <= 1'b1;
        air_rx_crc_ok <= crc;
        air_rx_is_ack <= is_ack;
        air_rx_has_payload <= pay;
        air_rx_pid <= ident;
        hop(1);
        air_rx_done <= 1'b0;
        air_rx_crc_ok <= 1'b0;
        air_rx_is_ack <= ~is_ack;
        air_rx_has_payload <= ~pay;
        air_rx_pid <= ~ident;
    endtask

    initial begin
        air_tx_done = 1'b0;
        air_addr_match = 1'b0;
        air_rx_done = 1'b0;
        air_rx_crc_ok = 1'b0;
        air_rx_is_ack = 1'b0;
        air_rx_has_payload = 1'b0;
        air_rx_pid = 2'h0;
        forever begin
            hop(1);
            if (air_tx_start === 1'b1) begin
                // Fixed time on air of eight cycles
                hop(8);
                air_tx_done <= 1'b1;
                hop(1);
                air_tx_done <= 1'b0;
                if (air_tx_is_ack !== 1'b1 && drop_ack !== 1'b1) begin
                    hop(ack_delay);
                    deliver(air_tx_pid, 1'b1, ack_pay, 1'b1);
                end
            end else if (inject === 1'b1) begin
                // Drop request spoils the checksum of an injected packet
                deliver(inj_ident, 1'b0, 1'b0, drop_ack !== 1'b1);
            end
        end
    end
endmodule // air_peer

// *** sim/tb.sv ***
// Self-checking bench of the auto-acknowledge link controller
`timescale 1ns/1ns
`include "link_defines.svh"

module tb;
    localparam logic [15:0] TURN = 16'h0014;
    localparam logic [15:0] SLOT = 16'h003C;
    logic                   core_clk, rst, radio_enable, primary_tx_mode, tx_pending, ack_payload_ready;
    logic [`RTX_W-1:0]      retransmit_limit, retransmit_counter;
    logic [`PID_W-1:0]      tx_pid, air_tx_pid, air_rx_pid, inj_ident;
    logic [`IRQ_N-1:0]      irq_clear;
    logic                   data_received_irq, data_sent_irq, retry_limit_irq, tx_pop, ack_payload_pop;
    logic                   air_tx_start, air_tx_is_ack, air_tx_with_payload, air_tx_done, air_rx_enable;
    logic                   air_addr_match, air_rx_done, air_rx_crc_ok, air_rx_is_ack, air_rx_has_payload;
    logic                   drop_ack, ack_pay, inject;
    logic [7:0]             ack_delay;
    int                     bad_count, total_checks;

    auto_ack_radio_transactions #(.TURN_CYC(TURN), .ACK_WAIT_CYC(SLOT)) i_auto_ack_radio_transactions (
        .core_clk, .rst, .radio_enable, .primary_tx_mode, .retransmit_limit, .tx_pending, .tx_pid,
        .ack_payload_ready, .irq_clear, .data_received_irq, .data_sent_irq, .retry_limit_irq, .tx_pop,
        .ack_payload_pop, .retransmit_counter, .air_tx_start, .air_tx_is_ack, .air_tx_with_payload,
        .air_tx_pid, .air_tx_done, .air_rx_enable, .air_addr_match, .air_rx_done, .air_rx_crc_ok,
        .air_rx_is_ack, .air_rx_has_payload, .air_rx_pid);

    air_peer i_air_peer (
        .core_clk, .air_tx_start, .air_tx_is_ack, .air_tx_pid, .air_tx_done, .air_addr_match, .air_rx_done,
        .air_rx_crc_ok, .air_rx_is_ack, .air_rx_has_payload, .air_rx_pid, .drop_ack, .ack_pay, .ack_delay,
        .inject, .inj_ident);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic chk_num(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: return air_tx_start;
            1: return tx_pop;
            2: return retry_limit_irq;
            3: return data_received_irq;
            4: return ack_payload_pop;
            default: return air_tx_done;
        endcase
    endfunction

    // Counts starts and pops on the way; a spent bound ends the run
    task automatic run_until(input int sel, input int lim, output int n, output int s, output int p);
        s = 0;
        p = 0;
        for (n = 1; n <= lim; n++) begin
            @(posedge core_clk);
            #1;
            if (air_tx_start === 1'b1) s++;
            if (tx_pop === 1'b1) p++;
            if (pick(sel) === 1'b1) return;
        end
        bad_count++;
        $display("unexpected output %0d: expected 1, seen 0", sel);
        give_verdict();
    endtask

    // Dropping enable also releases the lock left by a retry limit
    task automatic prep(input logic txm, input logic [1:0] id, input logic [3:0] lim, input logic drop,
                        input logic [7:0] dly, input logic pay);
        @(posedge core_clk);
        radio_enable <= 1'b0;
        tx_pending <= 1'b0;
        irq_clear <= 3'h7;
        repeat (3) @(posedge core_clk);
        irq_clear <= 3'h0;
        primary_tx_mode <= txm;
        tx_pid <= id;
        retransmit_limit <= lim;
        drop_ack <= drop;
        ack_delay <= dly;
        ack_pay <= pay;
        @(posedge core_clk);
        radio_enable <= 1'b1;
        tx_pending <= txm;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_basic();
        int n, s, p;
        prep(1'b1, 2'h1, 4'h3, 1'b0, 8'h05, 1'b0);
        run_until(0, 2000, n, s, p);
        chk_bit("start delay", 1'b1, n >= 1000 + TURN - 2 && n <= 1000 + TURN + 6);
        chk_bit("data is ack", 1'b0, air_tx_is_ack);
        chk_num("sent ident", 16'h0001, 16'(air_tx_pid));
        @(posedge core_clk);
        tx_pending <= 1'b0;
        run_until(5, 50, n, s, p);
        @(posedge core_clk);
        #1;
        chk_bit("receive after send", 1'b1, air_rx_enable);
        chk_bit("early sent flag", 1'b0, data_sent_irq);
        run_until(1, 100, n, s, p);
        repeat (2) @(posedge core_clk);
        #1;
        chk_bit("sent flag", 1'b1, data_sent_irq);
        chk_bit("receive flag", 1'b0, data_received_irq);
        chk_num("retransmits", 16'h0000, 16'(retransmit_counter));
        repeat (20) @(posedge core_clk);
        #1;
        chk_bit("sent flag held", 1'b1, data_sent_irq);
        @(posedge core_clk);
        irq_clear <= 3'h2;
        @(posedge core_clk);
        irq_clear <= 3'h0;
        #1;
        chk_bit("sent flag cleared", 1'b0, data_sent_irq);
        $display("basic transaction done");
    endtask

    task automatic t_retry();
        int n, s, p;
        prep(1'b1, 2'h2, 4'h2, 1'b1, 8'h05, 1'b0);
        run_until(2, 3000, n, s, p);
        chk_num("transmissions", 16'h0003, 16'(s));
        chk_num("pops", 16'h0000, 16'(p));
        chk_num("retransmits", 16'h0002, 16'(retransmit_counter));
        chk_num("resent ident", 16'h0002, 16'(air_tx_pid));
        chk_bit("sent flag", 1'b0, data_sent_irq);
        $display("retry limit done");
    endtask

    task automatic t_late_ack();
        int n, s, p;
        prep(1'b1, 2'h3, 4'h0, 1'b0, 8'h32, 1'b1);
        run_until(0, 2000, n, s, p);
        @(posedge core_clk);
        tx_pending <= 1'b0;
        run_until(1, 200, n, s, p);
        chk_num("late retransmits", 16'h0000, 16'(s));
        repeat (2) @(posedge core_clk);
        #1;
        chk_bit("retry flag", 1'b0, retry_limit_irq);
        chk_bit("sent flag", 1'b1, data_sent_irq);
        chk_bit("payload flag", 1'b1, data_received_irq);
        $display("late acknowledge done");
    endtask

    // Spacing between packets suits a host that uploads payloads
    task automatic send_pkt(input logic [1:0] id);
        repeat (13000) @(posedge core_clk);
        inject <= 1'b1;
        inj_ident <= id;
        @(posedge core_clk);
        inject <= 1'b0;
    endtask

    task automatic t_rx_node();
        int n, s, p;
        prep(1'b0, 2'h0, 4'h0, 1'b0, 8'h05, 1'b0);
        ack_payload_ready <= 1'b1;
        send_pkt(2'h1);
        run_until(3, 100, n, s, p);
        chk_bit("receive flag prompt", 1'b1, n <= 26);
        run_until(0, 100, n, s, p);
        chk_bit("ack kind", 1'b1, air_tx_is_ack);
        chk_bit("ack payload", 1'b1, air_tx_with_payload);
        chk_num("ack ident", 16'h0001, 16'(air_tx_pid));
        chk_bit("early payload flag", 1'b0, data_sent_irq);
        @(posedge core_clk);
        irq_clear <= 3'h1;
        @(posedge core_clk);
        irq_clear <= 3'h0;
        send_pkt(2'h1);
        run_until(0, 100, n, s, p);
        chk_bit("duplicate ack", 1'b1, air_tx_is_ack);
        chk_bit("duplicate flag", 1'b0, data_received_irq);
        chk_bit("duplicate payload flag", 1'b0, data_sent_irq);
        // Corrupted packet once the acknowledge is off the air
        repeat (20) @(posedge core_clk);
        drop_ack <= 1'b1;
        inject <= 1'b1;
        inj_ident <= 2'h2;
        @(posedge core_clk);
        drop_ack <= 1'b0;
        inject <= 1'b0;
        repeat (40) @(posedge core_clk);
        #1;
        chk_bit("bad checksum flag", 1'b0, data_received_irq);
        chk_bit("bad checksum listen", 1'b1, air_rx_enable);
        send_pkt(2'h2);
        run_until(4, 100, n, s, p);
        @(posedge core_clk);
        #1;
        chk_bit("new receive flag", 1'b1, data_received_irq);
        chk_bit("payload confirmed", 1'b1, data_sent_irq);
        run_until(0, 100, n, s, p);
        $display("receiving node done");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        radio_enable = 1'b0;
        primary_tx_mode = 1'b0;
        retransmit_limit = 4'h0;
        tx_pending = 1'b0;
        tx_pid = 2'h0;
        ack_payload_ready = 1'b0;
        irq_clear = 3'h0;
        drop_ack = 1'b0;
        ack_pay = 1'b0;
        ack_delay = 8'h05;
        inject = 1'b0;
        inj_ident = 2'h0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_basic();
        t_retry();
        t_late_ack();
        t_rx_node();
        give_verdict();
    end
endmodule // tb
